// File: core/scg_pkg.sv
// Shared constants for the sleep-mode clock gating block.
// Assumes a 32-bit AXI4-Lite register port and one system clock.
package scg_pkg;

    // Register byte offsets
    localparam logic [11:0] SCG_RUN_OFS = 12'h100;
    localparam logic [11:0] SCG_SLEEP_OFS = 12'h110;
    localparam logic [11:0] SCG_DEEP_OFS = 12'h120;
    localparam logic [11:0] SCG_CFG_OFS = 12'h130;
    localparam logic [11:0] SCG_INT_STAT_OFS = 12'h140;
    localparam logic [11:0] SCG_INT_MASK_OFS = 12'h144;
    localparam logic [11:0] SCG_CLK_STAT_OFS = 12'h148;

    // Gating field positions inside each gating register
    localparam int SCG_WDT_BIT = 3;
    localparam int SCG_PWM_BIT = 20;
    // Configuration register field
    localparam int SCG_AUTO_BIT = 0;

    // Whole-register reset value; bit 6 is a fixed read-only one
    localparam logic [31:0] SCG_GATE_RESET = 32'h0000_0040;
    localparam logic [31:0] SCG_GATE_RW_MASK = 32'h0010_0008;
    // Writable gate bits come up at zero
    localparam logic [1:0] SCG_GATE_BITS_RESET = 2'h0;

    // AXI responses
    localparam logic [1:0] SCG_RESP_OKAY = 2'h0;
    localparam logic [1:0] SCG_RESP_SLVERR = 2'h2;

    // Unit indices in the per-unit vectors
    localparam int SCG_UNIT_WDT = 0;
    localparam int SCG_UNIT_PWM = 1;

    // System power state seen from the power controller
    typedef enum logic [1:0] {
        SCG_RUN,
        SCG_SLEEP,
        SCG_DEEP
    } scg_power_type;

endpackage : scg_pkg

// File: core/scg_gate_if.sv
// Carrier between the gating controller and each clock gate cell.
// Assumes the gate cell sits in the same clock domain as the controller.
interface scg_gate_if;
    logic en; // Registered clock enable for one unit
    logic gclk; // Gated clock for that unit

    // Controller drives the enable and sees the gated clock
    modport ctrl (output en, input gclk);
    // Gate cell consumes the enable and makes the clock
    modport gate (input en, output gclk);
endinterface : scg_gate_if

// File: core/scg_clock_gate.sv
// Glitch-free clock gate cell for one unit.
// Assumes the enable changes only just after a rising edge of clk.
module scg_clock_gate (
    input wire logic clk,
    scg_gate_if.gate gateIf
);
    logic enLat; // Enable held while clk is high

    // Latch is open only while clk is low, so no runt pulses appear
    always_latch begin
        if (!clk) begin
            enLat = gateIf.en;
        end
    end

    assign gateIf.gclk = clk & enLat;

endmodule : scg_clock_gate

// File: core/scg_sleep_clock_gating.sv
// Clock gating control for run, sleep and deep-sleep power states.
// Assumes an AXI4-Lite master, a power controller giving the state, and
// one access strobe per gated unit from the peripheral bus decoder.
module scg_sleep_clock_gating
    import scg_pkg::*;
#(
    parameter int ADDR_W = 12, // Byte address width of the register port
    parameter int NUM_UNITS = 2 // Gated units: watchdog and PWM
) (
    input wire logic clk,
    input wire logic rst_n,
    // AXI4-Lite slave
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Power state from the power controller
    input wire logic [1:0] powerState,
    // Unit side
    input wire logic [NUM_UNITS-1:0] unitAccess,
    output logic [NUM_UNITS-1:0] unitFault,
    output logic [NUM_UNITS-1:0] unitClk,
    output logic [NUM_UNITS-1:0] unitClkEn,
    output logic [NUM_UNITS-1:0] unitHoldOff,
    output logic irq
);

    // Refuse shapes the decode and bit map cannot serve; checked while
    // elaborating so a bad build never reaches simulation
    if (ADDR_W < 9 || ADDR_W > 32) begin : gBadAddrW
        $error("ADDR_W must be 9 to 32");
    end
    if (NUM_UNITS != 2) begin : gBadUnits
        $error("NUM_UNITS must be 2");
    end

    ////////////////////////////////////////////////////////////////////
    // Register state
    logic [NUM_UNITS-1:0] runGate_q; // Run-mode enables
    logic [NUM_UNITS-1:0] sleepGate_q; // Sleep-mode enables
    logic [NUM_UNITS-1:0] deepGate_q; // Deep-sleep enables
    logic autoGate_q; // Auto gating select
    logic [NUM_UNITS-1:0] intStat_q; // Sticky fault events
    logic [NUM_UNITS-1:0] intMask_q; // Interrupt mask, one enables
    logic [NUM_UNITS-1:0] effEn_d; // Enable chosen for this state
    logic [NUM_UNITS-1:0] effEn_q;

    ////////////////////////////////////////////////////////////////////
    // AXI write channel capture
    logic awHeld_q; // Write address taken, waiting for data
    logic wHeld_q; // Write data taken, waiting for address
    logic [ADDR_W-1:0] awAddr_q;
    logic [31:0] wData_q;
    logic [3:0] wStrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic writeGo; // Both halves present, perform the write
    logic [11:0] wrOfs; // Register offset of the write
    logic wrHit; // Write hits a mapped register

    // Stop taking either half once it is held or a response waits
    assign awready = !awHeld_q && !bvalid_q;
    assign wready = !wHeld_q && !bvalid_q;
    assign writeGo = awHeld_q && wHeld_q && !bvalid_q;
    // Only the low twelve address bits take part in the decode
    assign wrOfs = 12'({awAddr_q[ADDR_W-1:2], 2'h0}) & 12'hffc;

    // Address half, taken independently of data
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            awHeld_q <= 1'b0;
            awAddr_q <= '0;
        end else if (awvalid && awready) begin
            awHeld_q <= 1'b1;
            awAddr_q <= awaddr;
        end else if (writeGo) begin
            awHeld_q <= 1'b0;
        end
    end

    // Data half, taken independently of address
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wHeld_q <= 1'b0;
            wData_q <= '0;
            wStrb_q <= '0;
        end else if (wvalid && wready) begin
            wHeld_q <= 1'b1;
            wData_q <= wdata;
            wStrb_q <= wstrb;
        end else if (writeGo) begin
            wHeld_q <= 1'b0;
        end
    end

    // Mapped offsets; anything else answers with a slave error
    always_comb begin
        case (wrOfs)
            SCG_RUN_OFS, SCG_SLEEP_OFS, SCG_DEEP_OFS, SCG_CFG_OFS,
            SCG_INT_STAT_OFS, SCG_INT_MASK_OFS: wrHit = 1'b1;
            default: wrHit = 1'b0; // Includes read-only status
        endcase
    end

    // Write response holds until the master takes it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bvalid_q <= 1'b0;
            bresp_q <= SCG_RESP_OKAY;
        end else if (writeGo) begin
            bvalid_q <= 1'b1;
            bresp_q <= wrHit ? SCG_RESP_OKAY : SCG_RESP_SLVERR;
        end else if (bready) begin
            bvalid_q <= 1'b0;
        end
    end
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;

    ////////////////////////////////////////////////////////////////////
    // Register writes
    logic [NUM_UNITS-1:0] wrGates; // Gate bits carried by the write
    logic wrLane0; // Byte lane 0 holds the watchdog bit
    logic wrLane2; // Byte lane 2 holds the PWM bit
    assign wrLane0 = wStrb_q[0];
    assign wrLane2 = wStrb_q[2];
    assign wrGates = {wData_q[SCG_PWM_BIT], wData_q[SCG_WDT_BIT]};

    // Merge the write into a gate vector lane by lane; reserved bits and
    // the fixed one never store anything
    function automatic logic [1:0] mergeGates(input logic [1:0] old);
        logic [1:0] res;
        res = old;
        if (wrLane0) begin
            res[SCG_UNIT_WDT] = wrGates[SCG_UNIT_WDT];
        end
        if (wrLane2) begin
            res[SCG_UNIT_PWM] = wrGates[SCG_UNIT_PWM];
        end
        return res;
    endfunction : mergeGates

    // The three gate registers; nothing sets them but software
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            runGate_q <= SCG_GATE_BITS_RESET;
            sleepGate_q <= SCG_GATE_BITS_RESET;
            deepGate_q <= SCG_GATE_BITS_RESET;
        end else if (writeGo) begin
            if (wrOfs == SCG_RUN_OFS) begin
                runGate_q <= mergeGates(runGate_q);
            end
            if (wrOfs == SCG_SLEEP_OFS) begin
                sleepGate_q <= mergeGates(sleepGate_q);
            end
            if (wrOfs == SCG_DEEP_OFS) begin
                deepGate_q <= mergeGates(deepGate_q);
            end
        end
    end

    // Configuration and interrupt mask
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            autoGate_q <= 1'b0;
            intMask_q <= '0;
        end else if (writeGo && wrLane0) begin
            if (wrOfs == SCG_CFG_OFS) begin
                autoGate_q <= wData_q[SCG_AUTO_BIT];
            end
            if (wrOfs == SCG_INT_MASK_OFS) begin
                intMask_q <= wData_q[NUM_UNITS-1:0];
            end
        end
    end

    // Fault events are sticky; a new fault wins over a write-one clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            intStat_q <= '0;
        end else begin
            for (int i = 0; i < NUM_UNITS; i++) begin
                if (unitFault[i]) begin
                    intStat_q[i] <= 1'b1;
                end else if (writeGo && wrLane0 &&
                             wrOfs == SCG_INT_STAT_OFS && wData_q[i]) begin
                    intStat_q[i] <= 1'b0;
                end
            end
        end
    end
    assign irq = |(intStat_q & intMask_q);

    ////////////////////////////////////////////////////////////////////
    // Effective enable selection
    // Without auto gating the run register rules in every state
    always_comb begin
        effEn_d = runGate_q;
        if (autoGate_q) begin
            case (scg_power_type'(powerState))
                SCG_SLEEP: effEn_d = sleepGate_q;
                SCG_DEEP: effEn_d = deepGate_q;
                default: effEn_d = runGate_q;
            endcase
        end
    end

    // Registered so the enable moves only right after an edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            effEn_q <= '0;
        end else begin
            effEn_q <= effEn_d;
        end
    end
    assign unitClkEn = effEn_q;
    assign unitHoldOff = ~effEn_q;

    // A unit touched while its clock is off answers with a fault
    assign unitFault = unitAccess & ~effEn_q;

    ////////////////////////////////////////////////////////////////////
    // Clock gate cells, one per unit
    for (genvar g = 0; g < NUM_UNITS; g++) begin : gGate
        scg_gate_if gateIf ();
        assign gateIf.en = effEn_q[g];
        assign unitClk[g] = gateIf.gclk;
        scg_clock_gate uGate (
            .clk(clk),
            .gateIf(gateIf.gate)
        );
    end

    ////////////////////////////////////////////////////////////////////
    // AXI read channel
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic [11:0] rdOfs;
    logic [31:0] rdVal; // Value of the addressed register
    logic rdHit;
    assign rdOfs = 12'({araddr[ADDR_W-1:2], 2'h0}) & 12'hffc;
    assign arready = !rvalid_q;

    // Place a gate vector at its documented bits; fixed one in bit 6
    function automatic logic [31:0] packGates(input logic [1:0] g);
        logic [31:0] v;
        v = SCG_GATE_RESET & ~SCG_GATE_RW_MASK;
        v[SCG_WDT_BIT] = g[SCG_UNIT_WDT];
        v[SCG_PWM_BIT] = g[SCG_UNIT_PWM];
        return v; // Bits other than the gates and bit 6 stay zero
    endfunction : packGates

    // Read decode
    always_comb begin
        rdVal = '0;
        rdHit = 1'b1;
        case (rdOfs)
            SCG_RUN_OFS: rdVal = packGates(runGate_q);
            SCG_SLEEP_OFS: rdVal = packGates(sleepGate_q);
            SCG_DEEP_OFS: rdVal = packGates(deepGate_q);
            SCG_CFG_OFS: rdVal[SCG_AUTO_BIT] = autoGate_q;
            SCG_INT_STAT_OFS: rdVal[NUM_UNITS-1:0] = intStat_q;
            SCG_INT_MASK_OFS: rdVal[NUM_UNITS-1:0] = intMask_q;
            SCG_CLK_STAT_OFS: rdVal = packGates(effEn_q);
            default: rdHit = 1'b0; // Unmapped, answer slave error
        endcase
    end

    // Read data holds until the master takes it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= SCG_RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid_q <= 1'b1;
            rdata_q <= rdVal;
            rresp_q <= rdHit ? SCG_RESP_OKAY : SCG_RESP_SLVERR;
        end else if (rready) begin
            rvalid_q <= 1'b0;
        end
    end
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;

    ////////////////////////////////////////////////////////////////////
    // Assertions
    logic firstCycle_q; // High only in the first cycle after reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            firstCycle_q <= 1'b1;
        end else begin
            firstCycle_q <= 1'b0;
        end
    end

    property p_reset_off;
        @(posedge clk) disable iff (!rst_n)
        firstCycle_q |-> (runGate_q == 2'h0) && (sleepGate_q == 2'h0)
            && (deepGate_q == 2'h0) && (unitClkEn == 2'h0);
    endproperty
    a_reset_off: assert property (p_reset_off)
        else $error("gates not off after reset");

    // Sampled at the falling edge, where the gated clock shows its high
    // phase; it carries the enable held over the preceding low phase
    property p_hold_off;
        @(negedge clk) disable iff (!rst_n)
        (unitHoldOff[SCG_UNIT_PWM] == !unitClkEn[SCG_UNIT_PWM])
            && (unitClk[SCG_UNIT_PWM] == $past(unitClkEn[SCG_UNIT_PWM]));
    endproperty
    a_hold_off: assert property (p_hold_off)
        else $error("PWM clocked while disabled");

    property p_fault;
        @(posedge clk) disable iff (!rst_n)
        unitAccess[SCG_UNIT_WDT] && !unitClkEn[SCG_UNIT_WDT]
            |-> unitFault[SCG_UNIT_WDT] ##1 intStat_q[SCG_UNIT_WDT];
    endproperty
    a_fault: assert property (p_fault)
        else $error("gated access gave no sticky fault");

    property p_no_fault;
        @(posedge clk) disable iff (!rst_n)
        unitClkEn[SCG_UNIT_PWM] |-> !unitFault[SCG_UNIT_PWM];
    endproperty
    a_no_fault: assert property (p_no_fault)
        else $error("fault on a clocked unit");

    property p_run_select;
        @(posedge clk) disable iff (!rst_n)
        !autoGate_q ##1 1'b1 |-> unitClkEn == $past(runGate_q);
    endproperty
    a_run_select: assert property (p_run_select)
        else $error("run register not used without auto gating");

    property p_sleep_select;
        @(posedge clk) disable iff (!rst_n)
        autoGate_q && powerState == SCG_SLEEP
            |=> unitClkEn == $past(sleepGate_q);
    endproperty
    a_sleep_select: assert property (p_sleep_select)
        else $error("sleep register not used in sleep");

    property p_deep_select;
        @(posedge clk) disable iff (!rst_n)
        autoGate_q && powerState == SCG_DEEP
            |=> unitClkEn == $past(deepGate_q);
    endproperty
    a_deep_select: assert property (p_deep_select)
        else $error("deep register not used in deep sleep");

    property p_pwm_write;
        @(posedge clk) disable iff (!rst_n)
        writeGo && wrOfs == SCG_SLEEP_OFS && wrLane2
            |=> sleepGate_q[SCG_UNIT_PWM] == $past(wData_q[SCG_PWM_BIT]);
    endproperty
    a_pwm_write: assert property (p_pwm_write)
        else $error("PWM sleep bit not written from bit 20");

    property p_wdt_write;
        @(posedge clk) disable iff (!rst_n)
        writeGo && wrOfs == SCG_DEEP_OFS && wrLane0
            |=> deepGate_q[SCG_UNIT_WDT] == $past(wData_q[SCG_WDT_BIT]);
    endproperty
    a_wdt_write: assert property (p_wdt_write)
        else $error("watchdog deep bit not written from bit 3");

    property p_reserved;
        @(posedge clk) disable iff (!rst_n)
        arvalid && arready && (rdOfs == SCG_SLEEP_OFS
            || rdOfs == SCG_DEEP_OFS || rdOfs == SCG_RUN_OFS)
            |=> (rdata & ~SCG_GATE_RW_MASK) == SCG_GATE_RESET;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved bits not as fixed");

    property p_bhold;
        @(posedge clk) disable iff (!rst_n)
        bvalid && !bready |=> bvalid && $stable(bresp);
    endproperty
    a_bhold: assert property (p_bhold)
        else $error("write response dropped early");

    c_sleep_write: cover property (@(posedge clk) disable iff (!rst_n)
        writeGo && wrOfs == SCG_SLEEP_OFS);
    c_fault: cover property (@(posedge clk) disable iff (!rst_n)
        unitFault[SCG_UNIT_PWM] && intMask_q[SCG_UNIT_PWM] ##1 irq);
    c_deep_on: cover property (@(posedge clk) disable iff (!rst_n)
        autoGate_q && powerState == SCG_DEEP && unitClkEn[SCG_UNIT_WDT]);

endmodule : scg_sleep_clock_gating

// File: verification/tb_scg_sleep_clock_gating.sv
// Self-checking bench for the sleep-mode clock gating block.
// Assumes the package is compiled first; the bench plays AXI master,
// power controller and peripheral decoder at once.
module tb_scg_sleep_clock_gating
    import scg_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;

    ////////////////////////////////////////////////////////////////////////
    // Stimulus and observed signals
    logic clk = 1'b0;
    logic rst_n = 1'b0; // Held low for the first 20 cycles
    logic [11:0] awaddr = 12'h000;
    logic awvalid = 1'b0;
    logic awready;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic wvalid = 1'b0;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic bready = 1'b0;
    logic [11:0] araddr = 12'h000;
    logic arvalid = 1'b0;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic rready = 1'b0;
    logic [1:0] powerState = 2'h0;
    logic [1:0] unitAccess = 2'h0;
    logic [1:0] unitFault, unitClk, unitClkEn, unitHoldOff;
    logic irq;
    int miscompares = 0;
    int nChecks = 0;
    // Gate registers in offset order: run, sleep, deep
    logic [11:0] gateOfs [3] = '{SCG_RUN_OFS, SCG_SLEEP_OFS, SCG_DEEP_OFS};
    // Expected enables per power state with automatic gating set
    logic [1:0] autoEn [4] = '{2'h1, 2'h2, 2'h3, 2'h1};

    // 100 MHz system clock
    always #5 clk = ~clk;

    scg_sleep_clock_gating #(.ADDR_W(12), .NUM_UNITS(2)) dut (
        .clk(clk), .rst_n(rst_n),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .powerState(powerState), .unitAccess(unitAccess),
        .unitFault(unitFault), .unitClk(unitClk), .unitClkEn(unitClkEn),
        .unitHoldOff(unitHoldOff), .irq(irq)
    );

    ////////////////////////////////////////////////////////////////////////
    // Compare tasks, one per kind of result
    task automatic checkData(input logic [31:0] got, input logic [31:0] exp);
        nChecks++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL at %0t: data %h expected %h", $time, got, exp);
        end
    endtask : checkData

    task automatic checkResp(input logic [1:0] got, input logic [1:0] exp);
        nChecks++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL at %0t: resp %h expected %h", $time, got, exp);
        end
    endtask : checkResp

    task automatic checkUnits(input logic [1:0] got, input logic [1:0] exp);
        nChecks++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL at %0t: units %h expected %h", $time, got, exp);
        end
    endtask : checkUnits

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite master; handshakes are judged at the falling edge so the
    // decision never races the design's own edge updates
    task automatic axiWrite(input logic [11:0] a, input logic [31:0] d,
            input logic [3:0] s, input logic [1:0] expResp);
        logic awTake, wTake, bTake;
        logic [1:0] resp;
        resp = 2'bxx;
        @(posedge clk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= s;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 50; n++) begin
            @(negedge clk);
            awTake = awvalid && awready;
            wTake = wvalid && wready;
            bTake = bvalid && bready;
            if (bTake) resp = bresp;
            @(posedge clk);
            // Each half is released only once taken
            if (awTake) awvalid <= 1'b0;
            if (wTake) wvalid <= 1'b0;
            if (bTake) begin
                bready <= 1'b0;
                break;
            end
        end
        checkResp(resp, expResp);
    endtask : axiWrite

    // Read data is compared only when an OKAY answer is expected
    task automatic axiRead(input logic [11:0] a, input logic [31:0] expData,
            input logic [1:0] expResp);
        logic arTake, rTake;
        logic [31:0] data;
        logic [1:0] resp;
        data = 32'hx;
        resp = 2'bxx;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 50; n++) begin
            @(negedge clk);
            arTake = arvalid && arready;
            rTake = rvalid && rready;
            if (rTake) begin
                data = rdata;
                resp = rresp;
            end
            @(posedge clk);
            if (arTake) arvalid <= 1'b0;
            if (rTake) begin
                rready <= 1'b0;
                break;
            end
        end
        checkResp(resp, expResp);
        if (expResp === SCG_RESP_OKAY) checkData(data, expData);
    endtask : axiRead

    // Effective enables settle one cycle after a change; three are allowed
    task automatic checkEnables(input logic [1:0] exp);
        repeat (3) @(posedge clk);
        @(negedge clk);
        checkUnits(unitClkEn, exp);
        checkUnits(unitHoldOff, ~exp);
        checkUnits(unitClk, 2'h0);
        @(posedge clk);
        #2;
        checkUnits(unitClk, exp); // Gated clock high phase
    endtask : checkEnables

    // Strobe one cycle of unit access and sample the fault mid-cycle
    task automatic pulseAccess(input logic [1:0] acc, input logic [1:0] exp);
        @(posedge clk);
        unitAccess <= acc;
        @(negedge clk);
        checkUnits(unitFault, exp); // Fault only on gated units
        @(posedge clk);
        unitAccess <= 2'h0;
        repeat (2) @(posedge clk);
    endtask : pulseAccess

    ////////////////////////////////////////////////////////////////////////
    // Verdict, reached from the main sequence or the watchdog
    task automatic conclude();
        $display("Checks %0d, mismatches %0d", nChecks, miscompares);
        if (miscompares == 0 && nChecks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : conclude

    // Watchdog against a hung handshake
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        conclude();
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        checkUnits(unitClkEn, SCG_GATE_BITS_RESET);
        checkUnits(unitHoldOff, 2'h3); // Units held off
        checkUnits({1'b0, irq}, 2'h0); // Quiet after reset
        foreach (gateOfs[i]) begin
            axiRead(gateOfs[i], SCG_GATE_RESET, SCG_RESP_OKAY);
            axiWrite(gateOfs[i], 32'hffff_ffff, 4'hf, SCG_RESP_OKAY);
            axiRead(gateOfs[i], SCG_GATE_RESET | SCG_GATE_RW_MASK,
                SCG_RESP_OKAY); // Only gate bits stick
            axiWrite(gateOfs[i], 32'h0, 4'hf, SCG_RESP_OKAY);
            axiRead(gateOfs[i], SCG_GATE_RESET, SCG_RESP_OKAY);
        end
        // Low byte strobe reaches the watchdog bit only
        axiWrite(SCG_SLEEP_OFS, 32'hffff_ffff, 4'h1, SCG_RESP_OKAY);
        axiRead(SCG_SLEEP_OFS, 32'h0000_0048, SCG_RESP_OKAY);
        // Unmapped and read-only places are refused
        axiWrite(12'h10c, 32'hffff_ffff, 4'hf, SCG_RESP_SLVERR);
        axiRead(12'h10c, 32'h0, SCG_RESP_SLVERR);
        axiWrite(SCG_CLK_STAT_OFS, 32'h8, 4'hf, SCG_RESP_SLVERR);
        // Distinct settings: run watchdog, sleep PWM, deep both
        // Software enables what it needs
        axiWrite(SCG_RUN_OFS, 32'h0000_0008, 4'hf, SCG_RESP_OKAY);
        axiWrite(SCG_SLEEP_OFS, 32'h0010_0000, 4'hf, SCG_RESP_OKAY);
        axiWrite(SCG_DEEP_OFS, 32'h0010_0008, 4'hf, SCG_RESP_OKAY);
        for (int auto = 0; auto < 2; auto++) begin
            axiWrite(SCG_CFG_OFS, 32'(auto), 4'hf, SCG_RESP_OKAY);
            for (int st = 0; st < 4; st++) begin
                @(posedge clk);
                powerState <= 2'(st);
                checkEnables(auto == 1 ? autoEn[st] : 2'h1);
            end
        end
        axiRead(SCG_CFG_OFS, 32'h1, SCG_RESP_OKAY);
        // Faults in run state: watchdog clocked, PWM gated
        @(posedge clk);
        powerState <= 2'h0;
        checkEnables(2'h1);
        axiRead(SCG_CLK_STAT_OFS, 32'h0000_0048, SCG_RESP_OKAY);
        axiWrite(SCG_INT_MASK_OFS, 32'h3, 4'hf, SCG_RESP_OKAY);
        pulseAccess(2'h3, 2'h2);
        checkUnits({1'b0, irq}, 2'h1); // Unmasked fault raises irq
        axiRead(SCG_INT_STAT_OFS, 32'h2, SCG_RESP_OKAY);
        axiWrite(SCG_INT_STAT_OFS, 32'h2, 4'hf, SCG_RESP_OKAY);
        axiRead(SCG_INT_STAT_OFS, 32'h0, SCG_RESP_OKAY); // Cleared by one
        checkUnits({1'b0, irq}, 2'h0); // Status cleared drops irq
        // Masked fault is recorded but stays silent
        axiWrite(SCG_INT_MASK_OFS, 32'h0, 4'hf, SCG_RESP_OKAY);
        pulseAccess(2'h1, 2'h0); // Clocked unit, no fault
        pulseAccess(2'h2, 2'h2);
        axiRead(SCG_INT_STAT_OFS, 32'h2, SCG_RESP_OKAY);
        checkUnits({1'b0, irq}, 2'h0); // Mask holds irq low
        // Reset in mid-run brings everything back to the power-on state
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        checkUnits(unitClkEn, SCG_GATE_BITS_RESET);
        axiRead(SCG_DEEP_OFS, SCG_GATE_RESET, SCG_RESP_OKAY);
        // Both units gated after reset, so both accesses fault
        pulseAccess(2'h3, 2'h3);
        axiRead(SCG_INT_STAT_OFS, 32'h3, SCG_RESP_OKAY);
        conclude();
    end

endmodule : tb_scg_sleep_clock_gating
